// ===== mwd_pkg.sv
// package: register map, field layout, reset values and timing for the millisecond watchdog
package mwd_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] MWD_IDX_PERIOD = 8'hD6;
  localparam logic [7:0] MWD_IDX_OFFKEY = 8'hD7;
  localparam logic [7:0] MWD_IDX_OSCMHZ = 8'hD8;
  localparam logic [9:0] MWD_ADDR_PERIOD = {MWD_IDX_PERIOD, 2'b00};
  localparam logic [9:0] MWD_ADDR_OFFKEY = {MWD_IDX_OFFKEY, 2'b00};
  localparam logic [9:0] MWD_ADDR_OSCMHZ = {MWD_IDX_OSCMHZ, 2'b00};
  localparam logic [9:0] MWD_ADDR_STATUS = 10'h0_364;
  // field positions
  localparam int MWD_PERIOD_LSB = 0;
  localparam int MWD_COUNT_LSB = 16;
  localparam int MWD_GUARD_LSB = 16;
  // reset values, the two keys and the oscillator limits
  localparam logic [15:0] MWD_PERIOD_RST = 16'h03E8;
  localparam logic [15:0] MWD_COUNT_RST = 16'h0000;
  localparam logic [31:0] MWD_OFF_KEY = 32'h0D15_AB1E;
  localparam logic [31:0] MWD_ON_KEY = 32'h0000_0000;
  localparam logic [6:0] MWD_OSC_RST = 7'h19;
  localparam logic [6:0] MWD_OSC_MIN = 7'h05;
  localparam logic [6:0] MWD_OSC_MAX = 7'h64;
  // tick: 1 ms = 1000 us; cycles per us equals the MHz setting
  localparam int MWD_TICK_US = 1000;
  localparam int MWD_CLK_MHZ = 20;
  localparam int MWD_RST_HOLD_CYC = 16;
  // status of the last register write
  typedef enum logic [1:0] {MWD_RSP_NONE, MWD_RSP_ACK, MWD_RSP_NACK} mwd_rsp_t;
  // register bus request carried as one struct
  typedef struct packed {
    logic wr;
    logic rd;
    logic [9:0] addr;
    logic [31:0] wdata;
  } mwd_req_t;
endpackage : mwd_pkg

// ===== mwd_watchdog.sv
// millisecond watchdog: registers, tick divider, countdown and tile reset
`timescale 1ns/1ns
// Notes on behaviour
// R1 - count drops once per millisecond tick
// R2 - 16-bit period field, resets to 1000
// R3 - live count readable in upper half
// R4 - count advances only while power_state_a
// R5 - accepted timeout write reloads the count
// R6 - software kicks before the period runs out
// R7 - software writes value with its complement
// R8 - bad complement gets nack, else ack
// R9 - expiry while enabled resets processor tile
// R10 - off key disables and clears counter
// R11 - writing zero enables the watchdog
// R12 - periods from 1 ms to 65 s
// R13 - tick derived from oscillator MHz setting
// R14 - complement high; rejected write changes nothing
// R15 - enabling loads counter from period first
module mwd_watchdog import mwd_pkg::*; #(
  parameter int TICK_US = MWD_TICK_US
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire mwd_req_t req,
  input wire logic power_state_a,
  output logic [31:0] rdata,
  output logic wr_ack,
  output logic wr_nack,
  output logic tile_reset
);
  // elaboration check: the 17-bit prescaler holds at most 100 MHz times 1000 us
  if (TICK_US < 1 || TICK_US > 1000) begin : g_bad_tick_us
    $error("TICK_US out of range");
  end

  // power_state_a pin synchroniser: three stages, change counts when 1 and 2 agree
  logic [2:0] power_state_a_sync_r;
  logic power_state_a_r;
  logic power_state_a_nxt;

  // registers
  logic [15:0] period_r, period_nxt;
  logic [15:0] count_r, count_nxt;
  logic [31:0] offkey_r, offkey_nxt;
  logic [6:0] osc_r, osc_nxt;
  logic enabled_r, enabled_nxt;
  logic [16:0] pre_r, pre_nxt;  // cycle prescaler toward one tick
  logic tick_r, tick_nxt;
  logic [31:0] rdata_nxt;
  logic ack_nxt, nack_nxt;
  logic trip_r, trip_nxt;  // tile reset pulse stretcher active
  logic [4:0] hold_r, hold_nxt;
  logic tile_reset_nxt;
  logic guard_ok;
  logic [16:0] tick_cycles;

  // tick length in system cycles: MHz setting times microseconds per tick
  assign tick_cycles = 17'(osc_r) * 17'(TICK_US);
  // the complement lives in the high half of the write data
  assign guard_ok = (req.wdata[MWD_GUARD_LSB +: 16] == ~req.wdata[MWD_PERIOD_LSB +: 16]);

  // next-state logic for the whole block except the power_state_a synchroniser shift register
  always_comb begin
    // power_state_a level moves only once the last two stages agree, so a pin glitch is ignored
    power_state_a_nxt = power_state_a_r;
    if (power_state_a_sync_r[1] == power_state_a_sync_r[2]) begin
      power_state_a_nxt = power_state_a_sync_r[2];
    end
    // by default the state registers keep their values, the answer strobes and read data fall
    period_nxt = period_r;
    count_nxt = count_r;
    offkey_nxt = offkey_r;
    osc_nxt = osc_r;
    enabled_nxt = enabled_r;
    ack_nxt = 1'b0;
    nack_nxt = 1'b0;
    trip_nxt = trip_r;
    hold_nxt = hold_r;
    tile_reset_nxt = trip_r;
    rdata_nxt = 32'h0000_0000;
    // R13 prescaler: one tick every osc_mhz * TICK_US cycles, only while power_state_a
    pre_nxt = pre_r;
    tick_nxt = 1'b0;
    // R4 power_state_a gating
    if (power_state_a_r && enabled_r) begin
      if (pre_r + 17'd1 >= tick_cycles) begin
        pre_nxt = 17'd0;
        tick_nxt = 1'b1;
      end else begin
        pre_nxt = pre_r + 17'd1;
      end
    end
    // R1 countdown once per tick
    // the stretcher freezes the count, so one expiry gives one pulse
    if (tick_r && enabled_r && power_state_a_r && !trip_r) begin
      if (count_r <= 16'd1) begin
        count_nxt = 16'd0;
        // R9 expiry starts tile reset
        trip_nxt = 1'b1;
        hold_nxt = 5'(MWD_RST_HOLD_CYC);
      end else begin
        count_nxt = count_r - 16'd1;
      end
    end
    // reset stretcher; count restarts from period after the pulse
    // hold_r runs from 16 down to 0, so the pulse lasts 17 cycles
    if (trip_r) begin
      if (hold_r == 5'd0) begin
        trip_nxt = 1'b0;
        count_nxt = period_r;
        pre_nxt = 17'd0;
      end else begin
        hold_nxt = hold_r - 5'd1;
      end
    end
    // register writes override the countdown in the same cycle
    // a kick on the very expiry tick reloads the count, but the tile reset still starts
    if (req.wr) begin
      unique case (req.addr)
        MWD_ADDR_PERIOD: begin
          // R8 guard check answer
          if (guard_ok) begin
            ack_nxt = 1'b1;
            // R12 any 16-bit period, 0 to 65535 ticks
            // R2 R5 store period and kick
            period_nxt = req.wdata[MWD_PERIOD_LSB +: 16];
            count_nxt = req.wdata[MWD_PERIOD_LSB +: 16];
            pre_nxt = 17'd0;
          end else begin
            // R14 rejected write changes nothing
            nack_nxt = 1'b1;
          end
        end
        MWD_ADDR_OFFKEY: begin
          ack_nxt = 1'b1;
          offkey_nxt = req.wdata;
          // only the two keys act; other values are kept for readback alone
          if (req.wdata == MWD_OFF_KEY) begin
            // R10 off key clears and disables
            enabled_nxt = 1'b0;
            count_nxt = MWD_COUNT_RST;
            pre_nxt = 17'd0;
          end else if (req.wdata == MWD_ON_KEY) begin
            // R11 zero enables
            enabled_nxt = 1'b1;
            // R15 load on enable edge
            if (!enabled_r) begin
              count_nxt = period_r;
              pre_nxt = 17'd0;
            end
          end
        end
        MWD_ADDR_OSCMHZ: begin
          // out-of-range frequencies are refused
          if (req.wdata[6:0] >= MWD_OSC_MIN && req.wdata[6:0] <= MWD_OSC_MAX
              && req.wdata[31:7] == 25'd0) begin
            osc_nxt = req.wdata[6:0];
            ack_nxt = 1'b1;
          end else begin
            nack_nxt = 1'b1;
          end
        end
        default: begin
          // unmapped address: ignored, answered with nack
          nack_nxt = 1'b1;
        end
      endcase
    end
    // read data one cycle after the strobe
    // zero outside a read, so several slaves can share an or-ed bus
    if (req.rd) begin
      unique case (req.addr)
        // R3 live count in upper half
        MWD_ADDR_PERIOD: rdata_nxt = {count_r, period_r};
        MWD_ADDR_OFFKEY: rdata_nxt = offkey_r;
        MWD_ADDR_OSCMHZ: rdata_nxt = {25'd0, osc_r};
        MWD_ADDR_STATUS: rdata_nxt = {29'd0, trip_r, power_state_a_r, enabled_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // register everything
  // synchronous reset: every register loads a constant
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      power_state_a_sync_r <= 3'b000;
      power_state_a_r <= 1'b0;
      period_r <= MWD_PERIOD_RST;
      count_r <= MWD_COUNT_RST;
      offkey_r <= MWD_OFF_KEY;
      osc_r <= MWD_OSC_RST;
      enabled_r <= 1'b0;
      pre_r <= 17'd0;
      tick_r <= 1'b0;
      rdata <= 32'h0000_0000;
      wr_ack <= 1'b0;
      wr_nack <= 1'b0;
      trip_r <= 1'b0;
      hold_r <= 5'd0;
      tile_reset <= 1'b0;
    end else begin
      // the pin enters stage 0; only stage 1 ever reads stage 0
      power_state_a_sync_r <= {power_state_a_sync_r[1:0], power_state_a};
      power_state_a_r <= power_state_a_nxt;
      period_r <= period_nxt;
      count_r <= count_nxt;
      offkey_r <= offkey_nxt;
      osc_r <= osc_nxt;
      enabled_r <= enabled_nxt;
      pre_r <= pre_nxt;
      tick_r <= tick_nxt;
      rdata <= rdata_nxt;
      wr_ack <= ack_nxt;
      wr_nack <= nack_nxt;
      trip_r <= trip_nxt;
      hold_r <= hold_nxt;
      tile_reset <= tile_reset_nxt;
    end
  end

  // assertions
  // R8 guard answer checked
  a_guard_nack: assert property (@(posedge clk_sys) disable iff (rst) // R8
    (req.wr && req.addr == MWD_ADDR_PERIOD && !guard_ok) |=> wr_nack && !wr_ack)
    else $error("bad guard not nacked");
  // R8 answers never both
  a_ack_exclusive: assert property (@(posedge clk_sys) disable iff (rst) // R8
    !(wr_ack && wr_nack))
    else $error("ack and nack together");
  // R14 rejected write ignored
  a_reject_keeps: assert property (@(posedge clk_sys) disable iff (rst) // R14
    (req.wr && req.addr == MWD_ADDR_PERIOD && !guard_ok) |=> $stable(period_r))
    else $error("rejected write changed period");
  // R5 kick reloads count
  a_kick_reload: assert property (@(posedge clk_sys) disable iff (rst) // R5
    (req.wr && req.addr == MWD_ADDR_PERIOD && guard_ok) |=> count_r == $past(req.wdata[15:0]))
    else $error("kick did not reload");
  // R5 count within period
  a_count_bound: assert property (@(posedge clk_sys) disable iff (rst) // R5
    count_r <= period_r)
    else $error("count above period");
  // R2 period read back
  a_read_period: assert property (@(posedge clk_sys) disable iff (rst) // R2
    (req.rd && req.addr == MWD_ADDR_PERIOD) |=> rdata[15:0] == $past(period_r))
    else $error("period readback wrong");
  // R10 off key stops
  a_off_key: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (req.wr && req.addr == MWD_ADDR_OFFKEY && req.wdata == MWD_OFF_KEY)
    |=> !enabled_r && count_r == 16'd0) else $error("off key failed");
  // R10 disabled count holds
  a_disabled_hold: assert property (@(posedge clk_sys) disable iff (rst) // R10
    (!enabled_r && !req.wr && !trip_r) |=> $stable(count_r))
    else $error("count moved while disabled");
  // R15 enable loads period
  a_enable_load: assert property (@(posedge clk_sys) disable iff (rst) // R15
    (req.wr && req.addr == MWD_ADDR_OFFKEY && req.wdata == 32'd0 && !enabled_r)
    |=> enabled_r && count_r == $past(period_r)) else $error("enable did not load");
  // R4 asleep count holds
  a_asleep_hold: assert property (@(posedge clk_sys) disable iff (rst) // R4
    (!power_state_a_r && !req.wr && !trip_r) |=> $stable(count_r)) else $error("count moved asleep");
  // R4 no tick asleep
  a_asleep_notick: assert property (@(posedge clk_sys) disable iff (rst) // R4
    !power_state_a_r |=> !tick_r)
    else $error("tick while asleep");
  // R9 expiry raises reset
  a_expiry_reset: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (tick_r && enabled_r && power_state_a_r && !trip_r && count_r == 16'd1 && !req.wr)
    |=> ##1 tile_reset) else $error("expiry gave no reset");
  // R9 pulse lasts 17
  a_pulse_len: assert property (@(posedge clk_sys) disable iff (rst) // R9
    $rose(tile_reset) |-> tile_reset[*8] ##1 tile_reset[*8] ##1 tile_reset ##1 !tile_reset)
    else $error("tile reset pulse length wrong");
  // R9 count frozen in pulse
  a_trip_freeze: assert property (@(posedge clk_sys) disable iff (rst) // R9
    (trip_r && hold_r != 5'd0 && !req.wr) |=> $stable(count_r))
    else $error("count moved during tile reset");
  // R1 one step per tick
  a_step_one: assert property (@(posedge clk_sys) disable iff (rst) // R1
    (tick_r && enabled_r && power_state_a_r && !trip_r && count_r > 16'd1 && !req.wr)
    |=> count_r == $past(count_r) - 16'd1) else $error("count step wrong");
  // R3 live count readable
  a_read_count: assert property (@(posedge clk_sys) disable iff (rst) // R3
    (req.rd && req.addr == MWD_ADDR_PERIOD) |=> rdata[31:16] == $past(count_r))
    else $error("count readback wrong");
  // R13 bad frequency refused
  a_osc_refuse: assert property (@(posedge clk_sys) disable iff (rst) // R13
    (req.wr && req.addr == MWD_ADDR_OSCMHZ
     && (req.wdata[6:0] < MWD_OSC_MIN || req.wdata[6:0] > MWD_OSC_MAX))
    |=> wr_nack && $stable(osc_r))
    else $error("bad frequency accepted");
  // R13 good frequency stored
  a_osc_accept: assert property (@(posedge clk_sys) disable iff (rst) // R13
    (req.wr && req.addr == MWD_ADDR_OSCMHZ && req.wdata[31:7] == 25'd0
     && req.wdata[6:0] >= MWD_OSC_MIN && req.wdata[6:0] <= MWD_OSC_MAX)
    |=> wr_ack && osc_r == $past(req.wdata[6:0]))
    else $error("good frequency refused");
  // cover points for the main scenarios
  c_kick: cover property (@(posedge clk_sys) wr_ack && enabled_r);
  c_nack: cover property (@(posedge clk_sys) wr_nack);
  c_expire: cover property (@(posedge clk_sys) $rose(tile_reset));
  c_tick: cover property (@(posedge clk_sys) tick_r && power_state_a_r);
  c_osc_set: cover property (@(posedge clk_sys) wr_ack && osc_r != MWD_OSC_RST);
endmodule : mwd_watchdog

// ===== mwd_tb.sv
// self-checking testbench for the millisecond watchdog
`timescale 1ns/1ns
module tb import mwd_pkg::*;;
  logic clk_sys;
  logic rst;
  mwd_req_t req; // register bus request
  logic power_state_a;
  logic [31:0] rdata;
  logic wr_ack;
  logic wr_nack;
  logic tile_reset;
  int miscompares;
  int n_compared;
  int n_rst = 0; // cycles seen with tile reset high
  logic [31:0] rd_v; // value of the last read
  logic [15:0] p_good; // last accepted period
  // short tick: one tick per 25 clocks keeps the run small
  mwd_watchdog #(.TICK_US(1)) i_mwd_watchdog (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(req),
    .power_state_a(power_state_a),
    .rdata(rdata),
    .wr_ack(wr_ack),
    .wr_nack(wr_nack),
    .tile_reset(tile_reset)
  );
  // 50 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // count reset cycles so gaps and pulse length can be judged
  always @(posedge clk_sys) begin
    if (tile_reset === 1'b1) n_rst <= n_rst + 1;
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk1
  // one write cycle, then the answer flags in the following cycle
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic ok);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
    chk1(wr_ack, ok);
    chk1(wr_nack, ~ok);
  endtask : wr
  // one read cycle; data stand only in the cycle after
  task automatic rd(input logic [9:0] a);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    rd_v = rdata;
  endtask : rd
  // period in the low half, its complement above
  function automatic logic [31:0] guard(input logic [15:0] p);
    return {~p, p};
  endfunction : guard
  task automatic test_done;
    $display("comparisons %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    logic [15:0] p;
    logic bad;
    int c;
    int c0;
    logic [6:0] osc_v;
    miscompares = 0;
    n_compared = 0;
    rst = 1'b1;
    power_state_a = 1'b0;
    req = '0;
    p_good = MWD_PERIOD_RST;
    void'($urandom(32'hc3fa));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values, then unmapped places
    rd(MWD_ADDR_PERIOD); chk32(rd_v, {MWD_COUNT_RST, MWD_PERIOD_RST});
    rd(MWD_ADDR_OFFKEY); chk32(rd_v, MWD_OFF_KEY);
    rd(10'h000); chk32(rd_v, 32'h0000_0000);
    wr(10'h004, 32'h0000_0001, 1'b0);
    // guarded writes while disabled, boundary periods first, some with one guard bit broken
    for (int i = 0; i < 12; i++) begin
      p = (i == 0) ? 16'h0001 : (i == 1) ? 16'hFFFF : 16'($urandom);
      bad = (i > 3) && ($urandom_range(1, 0) == 1);
      wr(MWD_ADDR_PERIOD, guard(p) ^ {bad ? 16'h0001 << $urandom_range(15, 0) : 16'h0000, 16'h0000}, ~bad);
      if (!bad) p_good = p;
      rd(MWD_ADDR_PERIOD); chk32(rd_v, {p_good, p_good});
    end
    // oscillator setting outside its range is refused
    wr(MWD_ADDR_OSCMHZ, 32'h0000_0004, 1'b0);
    wr(MWD_ADDR_OSCMHZ, 32'h0000_0065, 1'b0);
    rd(MWD_ADDR_OSCMHZ); chk32(rd_v, {25'h000_0000, MWD_OSC_RST});
    // a random legal frequency is kept, then the default is put back
    osc_v = 7'($urandom_range(MWD_OSC_MAX, MWD_OSC_MIN));
    wr(MWD_ADDR_OSCMHZ, {25'h000_0000, osc_v}, 1'b1);
    rd(MWD_ADDR_OSCMHZ); chk32(rd_v, {25'h000_0000, osc_v});
    wr(MWD_ADDR_OSCMHZ, {25'h000_0000, MWD_OSC_RST}, 1'b1);
    // power_state_a and enabled: ten ticks of 25 clocks
    wr(MWD_ADDR_PERIOD, guard(16'h00C8), 1'b1);
    power_state_a <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wr(MWD_ADDR_OFFKEY, MWD_ON_KEY, 1'b1);
    repeat (250) @(posedge clk_sys);
    rd(MWD_ADDR_PERIOD);
    c = rd_v[31:16];
    chk1(c inside {[189:191]}, 1'b1);
    // status: enabled and power_state_a, no tile reset
    rd(MWD_ADDR_STATUS); chk32(rd_v, 32'h0000_0003);
    // asleep: the count holds
    power_state_a <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rd(MWD_ADDR_PERIOD);
    c0 = rd_v;
    repeat (100) @(posedge clk_sys);
    rd(MWD_ADDR_PERIOD); chk32(rd_v, c0);
    // kicks well inside a 100 clock period keep the tile alive
    power_state_a <= 1'b1;
    repeat (10) @(posedge clk_sys);
    c0 = n_rst;
    repeat (8) begin
      repeat (55) @(posedge clk_sys);
      wr(MWD_ADDR_PERIOD, guard(16'h0004), 1'b1);
    end
    chk1(n_rst == c0, 1'b1);
    // no kick: one reset pulse of 17 cycles, next expiry still ahead
    c0 = n_rst;
    repeat (150) @(posedge clk_sys);
    chk1(n_rst - c0 == 17, 1'b1);
    // off key stops it; another value is stored but changes nothing
    wr(MWD_ADDR_OFFKEY, MWD_OFF_KEY, 1'b1);
    wr(MWD_ADDR_OFFKEY, 32'h1234_5678, 1'b1);
    rd(MWD_ADDR_OFFKEY); chk32(rd_v, 32'h1234_5678);
    c0 = n_rst;
    rd(MWD_ADDR_PERIOD);
    c = rd_v;
    repeat (300) @(posedge clk_sys);
    rd(MWD_ADDR_PERIOD); chk32(rd_v, c);
    chk1(n_rst == c0, 1'b1);
    // a second reset mid-run brings back every reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(MWD_ADDR_PERIOD); chk32(rd_v, {MWD_COUNT_RST, MWD_PERIOD_RST});
    rd(MWD_ADDR_OFFKEY); chk32(rd_v, MWD_OFF_KEY);
    rd(MWD_ADDR_OSCMHZ); chk32(rd_v, {25'h000_0000, MWD_OSC_RST});
    test_done();
  end
  // the run needs about 1400 clocks; cut a hang well after that
  initial begin
    #(50 * 10000);
    miscompares++;
    test_done();
  end
endmodule : tb
